/* File: hw/txhic_pkg.sv */
// package: register map, field layout and types for the transmit channel indirect access port
package txhic_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] TXHIC_SEL_OFFSET = 12'h380; // tx_channel_indirect_select
    localparam logic [11:0] TXHIC_DATA1_OFFSET = 12'h384; // indirect channel data one
    localparam logic [11:0] TXHIC_DATA2_OFFSET = 12'h388; // indirect channel data two
    localparam logic [11:0] TXHIC_DATA3_OFFSET = 12'h38C; // indirect channel data three

    // ************************************************************
    // select register fields
    // ************************************************************
    localparam int TXHIC_INDIRECT_CHANNEL_NUMBER_LSB = 0; // indirect_channel_number low bit
    localparam int TXHIC_INDIRECT_CHANNEL_NUMBER_MSB = 6; // indirect_channel_number high bit
    localparam int TXHIC_RNW_BIT = 14; // indirect_read_not_write
    localparam int TXHIC_BUSY_BIT = 15; // busy flag
    localparam logic [6:0] TXHIC_INDIRECT_CHANNEL_NUMBER_RESET = 7'h00; // channel reset value
    localparam logic TXHIC_RNW_RESET = 1'h0; // direction reset value

    // ************************************************************
    // data register one fields
    // ************************************************************
    localparam int TXHIC_CHANNEL_PROVISION_ENABLE_BIT = 15; // channel_provision_enable
    localparam int TXHIC_CRC_MSB = 14; // crc select high bit
    localparam int TXHIC_CRC_LSB = 13; // crc select low bit
    localparam int TXHIC_IDLE_BIT = 12; // idle fill
    localparam int TXHIC_DELINEATE_ENABLE_BIT = 11; // delineate_enable
    localparam int TXHIC_PTR_MSB = 8; // fifo_block_pointer high bit
    localparam int TXHIC_PTR_LSB = 0; // fifo_block_pointer low bit

    // ************************************************************
    // data register one / two / three layout (16 bits stored each)
    // ************************************************************
    localparam int TXHIC_DATA_W = 16; // stored width of each data register
    localparam logic [15:0] TXHIC_DATA_RESET = 16'h0000; // data register reset value
    localparam logic [15:0] TXHIC_D1_RD_MASK = 16'hF800; // readable bits of data one
    localparam logic [15:0] TXHIC_D2_RD_MASK = 16'hF000; // readable bits of data two
    localparam logic [15:0] TXHIC_D3_RD_MASK = 16'hFFFF; // readable bits of data three

    // ************************************************************
    // provision ram and access timing
    // ************************************************************
    localparam int TXHIC_CHANNELS = 128; // entries in provision ram
    localparam logic [1:0] TXHIC_ACCESS_CYCLES = 2'h2; // wait count loaded on trigger; an access stays busy for 3 cycles

    // crc selection encodings
    typedef enum logic [1:0]
    {
        TXHIC_CRC_NONE = 2'b00,
        TXHIC_CRC_CCITT = 2'b01,
        TXHIC_CRC_32 = 2'b10,
        TXHIC_CRC_RSVD = 2'b11
    } txhic_crc_t;

    // access sequencer states
    typedef enum logic [1:0]
    {
        TXHIC_IDLE = 2'b00,
        TXHIC_WAIT = 2'b01,
        TXHIC_DONE = 2'b10
    } txhic_state_t;

    // one provision ram entry: the three data registers
    typedef struct packed
    {
        logic [15:0] d3;
        logic [15:0] d2;
        logic [15:0] d1;
    } txhic_entry_t;

    // decoded view of data register one
    typedef struct packed
    {
        logic provision_enable;
        txhic_crc_t crc_select;
        logic idle_fill;
        logic delineate_enable;
        logic [8:0] fifo_block_pointer;
    } txhic_cfg_t;

    // ram request from sequencer to ram
    typedef struct packed
    {
        logic write;
        logic read;
        logic [6:0] index;
        txhic_entry_t wdata;
    } txhic_ram_req_t;

endpackage

/* File: hw/txhic_ram.sv */
// module: channel provision ram, one entry per channel, registered read
`timescale 1ns/1ns
module txhic_ram
    import txhic_pkg::*;
(
    input wire logic mclk,
    input wire txhic_ram_req_t req,
    output txhic_entry_t rdata
);

    // ************************************************************
    // storage
    // ************************************************************
    txhic_entry_t mem [TXHIC_CHANNELS]; // provision entries, no reset (ram)

    // write on request, registered read data
    always_ff @(posedge mclk)
    begin
        if (req.write)
        begin
            mem[req.index] <= req.wdata;
        end
        if (req.read)
        begin
            rdata <= mem[req.index];
        end
    end

endmodule

/* File: hw/txhic_top.sv */
// module: transmit hdlc channel indirect access register bank
// ************************************************************
// ************************************************************
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module txhic_top
    import txhic_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output txhic_cfg_t active_cfg,
    output txhic_crc_t active_crc,
    output logic busy
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        txhic_state_t state;
        logic [1:0] count;
        logic busy;
        logic [6:0] indirect_channel_number;
        logic rnw;
        txhic_entry_t data;
        logic [31:0] rdata;
        txhic_cfg_t cfg;
    } txhic_regs_t;

    txhic_regs_t r; // registered state
    txhic_regs_t next_r; // next state
    txhic_ram_req_t ram_req; // ram request
    txhic_entry_t ram_rdata; // ram read data
    logic sel_write; // host write to select register
    txhic_cfg_t data1_view; // data one decoded

    // ************************************************************
    // provision ram
    // ************************************************************
    txhic_ram txhic_ram_i
    (
        .mclk(mclk),
        .req(ram_req),
        .rdata(ram_rdata)
    );

    assign sel_write = reg_write && (reg_addr == TXHIC_SEL_OFFSET);
    assign data1_view = txhic_cfg_t'({r.data.d1[TXHIC_CHANNEL_PROVISION_ENABLE_BIT],
        r.data.d1[TXHIC_CRC_MSB:TXHIC_CRC_LSB], r.data.d1[TXHIC_IDLE_BIT],
        r.data.d1[TXHIC_DELINEATE_ENABLE_BIT], r.data.d1[TXHIC_PTR_MSB:TXHIC_PTR_LSB]});

    // ram request issued in the trigger cycle
    always_comb
    begin
        ram_req.write = sel_write && !reg_wdata[TXHIC_RNW_BIT];
        ram_req.read = sel_write && reg_wdata[TXHIC_RNW_BIT];
        ram_req.index = reg_wdata[TXHIC_INDIRECT_CHANNEL_NUMBER_MSB:TXHIC_INDIRECT_CHANNEL_NUMBER_LSB];
        ram_req.wdata = r.data;
    end

    // ************************************************************
    // next state logic
    // ************************************************************
    always_comb
    begin
        next_r = r;
        next_r.rdata = 32'h0000_0000;
        // host register writes to data registers
        if (reg_write)
        begin
            case (reg_addr)
                TXHIC_DATA1_OFFSET: next_r.data.d1 = reg_wdata[15:0];
                TXHIC_DATA2_OFFSET: next_r.data.d2 = reg_wdata[15:0];
                TXHIC_DATA3_OFFSET: next_r.data.d3 = reg_wdata[15:0];
                default: ;
            endcase
        end
        // access sequencer
        case (r.state)
            TXHIC_IDLE:
            begin
                next_r.busy = 1'b0;
            end
            TXHIC_WAIT:
            begin
                next_r.count = r.count - 2'h1;
                if (r.count == 2'h1)
                begin
                    next_r.state = TXHIC_DONE;
                end
            end
            TXHIC_DONE:
            begin
                // completion: a read overwrites data registers
                if (r.rnw)
                begin
                    next_r.data = ram_rdata;
                end
                // write path: publish decoded fields of last write
                if (!r.rnw)
                begin
                    next_r.cfg = data1_view;
                end
                next_r.busy = 1'b0;
                next_r.state = TXHIC_IDLE;
            end
            default:
            begin
                next_r.state = TXHIC_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
        // trigger wins over everything else
        if (sel_write)
        begin
            next_r.indirect_channel_number = reg_wdata[TXHIC_INDIRECT_CHANNEL_NUMBER_MSB:TXHIC_INDIRECT_CHANNEL_NUMBER_LSB];
            next_r.rnw = reg_wdata[TXHIC_RNW_BIT];
            next_r.busy = 1'b1;
            next_r.count = TXHIC_ACCESS_CYCLES;
            next_r.state = TXHIC_WAIT;
        end
        // read data, one cycle after strobe
        if (reg_read)
        begin
            case (reg_addr)
                TXHIC_SEL_OFFSET:
                begin
                    next_r.rdata[TXHIC_BUSY_BIT] = r.busy;
                    next_r.rdata[TXHIC_RNW_BIT] = r.rnw;
                    next_r.rdata[TXHIC_INDIRECT_CHANNEL_NUMBER_MSB:TXHIC_INDIRECT_CHANNEL_NUMBER_LSB] = r.indirect_channel_number;
                end
                TXHIC_DATA1_OFFSET: next_r.rdata[15:0] = r.data.d1 & TXHIC_D1_RD_MASK;
                TXHIC_DATA2_OFFSET: next_r.rdata[15:0] = r.data.d2 & TXHIC_D2_RD_MASK;
                TXHIC_DATA3_OFFSET: next_r.rdata[15:0] = r.data.d3 & TXHIC_D3_RD_MASK;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            r.state <= TXHIC_IDLE;
            r.count <= 2'h0;
            r.busy <= 1'b0;
            r.indirect_channel_number <= TXHIC_INDIRECT_CHANNEL_NUMBER_RESET;
            r.rnw <= TXHIC_RNW_RESET;
            r.data <= {TXHIC_DATA_RESET, TXHIC_DATA_RESET, TXHIC_DATA_RESET};
            r.rdata <= 32'h0000_0000;
            r.cfg <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata = r.rdata;
    assign busy = r.busy;
    assign active_cfg = r.cfg;
    // crc ignored when delineation is off
    assign active_crc = r.cfg.delineate_enable ? r.cfg.crc_select : TXHIC_CRC_NONE;

endmodule

/* File: tb/txhic_chk.sv */
// checker: port assertions for the transmit channel indirect access bank
`timescale 1ns/1ns
module txhic_chk
    import txhic_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire txhic_cfg_t active_cfg,
    input wire txhic_crc_t active_crc,
    input wire logic busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // select write and register read decodes
    wire logic sel_wr = reg_write && reg_addr == TXHIC_SEL_OFFSET;
    wire logic sel_rd = reg_read && reg_addr == TXHIC_SEL_OFFSET;
    wire logic d1_rd = reg_read && reg_addr == TXHIC_DATA1_OFFSET;
    property p_busy_len; sel_wr && !busy |=> busy [*3] ##1 !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_busy_rise; $rose(busy) |-> $past(sel_wr); endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy cause");
    property p_busy_bit; $past(sel_rd) |-> reg_rdata[15] == $past(busy); endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit");
    property p_sel_rsvd; $past(sel_rd) |-> reg_rdata[31:16] == 0 && reg_rdata[13:7] == 0;
    endproperty
    a_sel_rsvd: assert property (p_sel_rsvd) else $error("select layout");
    property p_ptr_wo; $past(d1_rd) |-> reg_rdata[10:0] == 0; endproperty
    a_ptr_wo: assert property (p_ptr_wo) else $error("pointer readable");
    property p_crc;
        active_crc == (active_cfg.delineate_enable ? active_cfg.crc_select : TXHIC_CRC_NONE);
    endproperty
    a_crc: assert property (p_crc) else $error("crc gating");
    property p_cfg_hold; !$fell(busy) |-> $stable(active_cfg); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed");
    property p_reset; $past(!reset_n) |-> !busy && reg_rdata == 0 && active_cfg == 0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values");
    // main scenarios
    c_wr: cover property (sel_wr && !reg_wdata[14]);
    c_rd: cover property (sel_wr && reg_wdata[14]);
    c_done: cover property ($fell(busy));
endmodule
bind txhic_top txhic_chk txhic_chk_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .active_cfg(active_cfg), .active_crc(active_crc), .busy(busy));

/* File: tb/txhic_top_bench.sv */
// testbench: scenarios for the transmit channel indirect access bank
`timescale 1ns/1ns
module txhic_top_bench
    import txhic_pkg::*;
();
    logic mclk, reset_n, reg_write, reg_read, busy;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    txhic_cfg_t active_cfg;
    txhic_crc_t active_crc;
    int fails, cmp_count;
    txhic_top txhic_top_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .active_cfg(active_cfg), .active_crc(active_crc), .busy(busy));
    // ************************************************************
    // bus tasks
    // ************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask
    // trigger an access, then poll busy low before anything else
    task access(input logic rnw, input logic [6:0] ch);
        int n;
        wr(TXHIC_SEL_OFFSET, {16'h0000, 1'b0, rnw, 7'h00, ch});
        chk("busy", 32'h1, {31'h0, busy});
        n = 0;
        while (busy !== 1'b0 && n < 10)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("busy cycles", 32'h3, n);
        if (n == 10)
            summarize();
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        rd(TXHIC_SEL_OFFSET, 32'h0, "select");
        rd(TXHIC_DATA1_OFFSET, 32'h0, "data one");
        $display("test reset done");
    endtask
    task t_unmapped;
        wr(12'h390, 32'h0000FFFF);
        chk("busy unmapped", 32'h0, {31'h0, busy});
        rd(12'h390, 32'h0, "unmapped");
        $display("test unmapped done");
    endtask
    task t_write_read;
        wr(TXHIC_DATA1_OFFSET, 32'h0000F9FF);
        wr(TXHIC_DATA2_OFFSET, 32'h0000F1FF);
        wr(TXHIC_DATA3_OFFSET, 32'h0000A5C3);
        access(1'b0, 7'h7F);
        chk("active cfg", 32'h3FFF, {18'h0, active_cfg});
        rd(TXHIC_SEL_OFFSET, 32'h0000007F, "select");
        wr(TXHIC_DATA1_OFFSET, 32'h0);
        wr(TXHIC_DATA2_OFFSET, 32'h0);
        wr(TXHIC_DATA3_OFFSET, 32'h0);
        rd(TXHIC_DATA3_OFFSET, 32'h0, "data three held");
        access(1'b1, 7'h7F);
        rd(TXHIC_SEL_OFFSET, 32'h0000407F, "select read");
        rd(TXHIC_DATA1_OFFSET, 32'h0000F800, "data one");
        rd(TXHIC_DATA2_OFFSET, 32'h0000F000, "data two");
        rd(TXHIC_DATA3_OFFSET, 32'h0000A5C3, "data three");
        // busy seen through the select register while an access runs
        wr(TXHIC_SEL_OFFSET, 32'h0000407F);
        rd(TXHIC_SEL_OFFSET, 32'h0000C07F, "select busy");
        rd(TXHIC_SEL_OFFSET, 32'h0000407F, "select idle");
        $display("test write read done");
    endtask
    // every crc code with delineation off and on, one channel each
    task t_crc;
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            wr(TXHIC_DATA1_OFFSET, {16'h0, c[0], c[1:0], ~c[0], c[2], 8'h00, c});
            access(1'b0, {4'h0, c});
            chk("crc", {30'h0, c[2] ? c[1:0] : 2'b00}, {30'h0, active_crc});
            chk("cfg", {18'h0, c[0], c[1:0], ~c[0], c[2], 6'h00, c}, {18'h0, active_cfg});
        end
        access(1'b1, 7'h03);
        rd(TXHIC_DATA1_OFFSET, 32'h0000E000, "channel three");
        $display("test crc done");
    endtask
    // reset in mid-run clears the select and data registers
    task t_reset_again;
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(TXHIC_SEL_OFFSET, 32'h0, "select after reset");
        chk("cfg after reset", 32'h0, {18'h0, active_cfg});
        rd(TXHIC_DATA1_OFFSET, 32'h0, "data one after reset");
        $display("test reset again done");
    endtask
    initial
    begin
        reset_n = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        fails = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_unmapped();
        t_write_read();
        t_crc();
        t_reset_again();
        summarize();
    end
endmodule
